// *** verif/pes_core_model.sv ***
// Core-side model: per-cycle conditions and reference clock pulses
`timescale 1ns/1ps
module pes_core_model (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire pes_pkg::pes_cond_s cond_req_in,
    output pes_pkg::pes_cond_s      cond_out,
    output logic                    ref_clock_pulse_out
);
    logic [1:0] phase;
    logic [1:0] next_phase;
    always_comb next_phase = phase + 2'h1;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            phase <= 2'h0;
        else
            phase <= next_phase;
    end
    // Conditions are levels of the current cycle, so they pass straight through
    assign cond_out = cond_req_in;
    // One rising pulse edge every four core cycles
    assign ref_clock_pulse_out = phase[1];
endmodule : pes_core_model

// *** verif/tb.sv ***
// Self-checking testbench for the performance event select decoder
`timescale 1ns/1ps
module tb;
    logic               clk_in;
    logic               rst_n_in = 1'b0;
    pes_pkg::pes_cond_s cond_req = '0;
    pes_pkg::pes_cond_s cond;
    logic               ref_pulse, awready, wready, bvalid, arready, rvalid;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0;
    logic [1:0]         bresp, rresp, resp;
    logic [7:0]         awaddr = 8'h00, araddr = 8'h00, incr;
    logic [31:0]        wdata = 32'h0, rdata, rd, s;
    logic [3:0]         wstrb = 4'hf;
    int                 mismatches = 0, checked = 0;
    // Row: event, unit mask, threshold, condition bit position, value, expected increment
    logic [47:0]        rows [31] = '{
        48'h24e400450101, 48'h24e700440101, 48'h24e400440100, 48'h24f800430101,
        48'h24ef00420101, 48'h2e4f00410101, 48'h2e4100400101, 48'h3c0000000001,
        48'h3c0000470100, 48'h480100380505, 48'h480101380501, 48'h480200370101,
        48'h480200360100, 48'h490100350101, 48'h490e00340101, 48'h4910002c0303,
        48'h4910012c0301, 48'h4920002b0101, 48'h4c01002a0101, 48'h4f1000220404,
        48'h510100210101, 48'h5e0100200101, 48'h600100180707, 48'h600106180500,
        48'h600106180601, 48'h600201100201, 48'h600400080909, 48'h600401080901,
        48'h600800000b0b, 48'h240000420100, 48'h770100220400};
    pes_core_model u_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .cond_req_in(cond_req),
        .cond_out(cond), .ref_clock_pulse_out(ref_pulse));
    pes_decoder dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cond_in(cond),
        .ref_clock_pulse_in(ref_pulse), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .increment_out(incr));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One AXI4-Lite write or read; waits for the response however long it takes
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        forever begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (wr ? bvalid : rvalid) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        rd = rdata;
        resp = wr ? bresp : rresp;
    endtask : bus
    task automatic sum(input int n);
        s = 32'h0;
        repeat (n) begin
            @(posedge clk_in);
            #1 s = s + {24'h0, incr};
        end
    endtask : sum
    task automatic stop_test();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, pes_pkg::SELECT_RESET);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, pes_pkg::COUNT_RESET);
        bus(1'b0, 8'h08, 32'h0);
        chk({30'h0, resp}, {30'h0, pes_pkg::RESP_SLVERR});
        bus(1'b1, 8'h0c, 32'h1);
        chk({30'h0, resp}, {30'h0, pes_pkg::RESP_SLVERR});
        bus(1'b1, 8'h00, 32'hffff_ffff);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, pes_pkg::SELECT_WMASK);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h04, 32'h1234);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h1234);
        wstrb <= 4'h1;
        bus(1'b1, 8'h04, 32'hffff_ffab);
        wstrb <= 4'hf;
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0000_12ab);
        $display("register test done");
        foreach (rows[i]) begin
            bus(1'b1, 8'h00, {rows[i][31:24], 8'h08, rows[i][39:32], rows[i][47:40]});
            cond_req <= pes_pkg::pes_cond_s'(72'(rows[i][15:8]) << rows[i][23:16]);
            repeat (3) @(posedge clk_in);
            #1 chk({24'h0, incr}, {24'h0, rows[i][7:0]});
        end
        $display("event table test done");
        @(posedge clk_in);
        cond_req <= pes_pkg::pes_cond_s'(72'h1 << 71);
        bus(1'b1, 8'h00, 32'h000a_003c);
        sum(8);
        chk(s, 32'h8);
        bus(1'b1, 8'h00, 32'h000a_013c);
        sum(40);
        chk(s, 32'ha);
        bus(1'b1, 8'h00, 32'h0008_023c);
        cond_req <= pes_pkg::pes_cond_s'(72'h1 << 70);
        sum(40);
        chk(s, 32'ha);
        @(posedge clk_in);
        cond_req <= '0;
        sum(40);
        chk(s, 32'h0);
        $display("reference pulse test done");
        @(posedge clk_in);
        cond_req <= pes_pkg::pes_cond_s'(72'h1 << 32);
        bus(1'b1, 8'h00, 32'h010d_015e);
        sum(3);
        sum(4);
        chk(s, 32'h0);
        @(posedge clk_in);
        cond_req <= '0;
        sum(6);
        chk(s, 32'h1);
        $display("empty period end test done");
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 chk({29'h0, bvalid, rvalid, awready}, 32'h0);
        chk({24'h0, incr}, 32'h0);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, pes_pkg::SELECT_RESET);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, pes_pkg::COUNT_RESET);
        $display("mid-run reset test done");
        stop_test();
    end
endmodule : tb

// *** verilog/pes_decoder.sv ***
// Performance event select decoder with AXI4-Lite register access
// Behaviour
// - 24H/E4H counts level-two code requests; 24H/E7H counts level-two demand requests.
// - 24H/F8H counts prefetch requests to level two; 24H/EFH counts all requests.
// - 2EH/4FH counts third-level references; 2EH/41H counts third-level misses.
// - 3CH/00H counts core cycles while this thread is not halted.
// - Any-thread on 3CH/00H and 3CH/01H counts when either thread is unhalted.
// - 3CH/01H counts 100 MHz reference pulses while the thread is unhalted.
// - 3CH/02H counts reference pulses while this thread runs and sibling halts.
// - 48H/01H adds outstanding data cache misses; threshold one counts busy cycles.
// - 48H/02H counts demand requests finding no free fill buffer; hardware prefetch excluded.
// - 49H/01H counts store walk starts; 49H/0EH counts completed store walks.
// - 49H/10H adds busy store walkers; threshold one counts cycles with any busy.
// - 49H/20H counts store data TLB misses that hit the second-level TLB.
// - 4CH/01H counts demand loads hitting a software-prefetch fill buffer.
// - 4FH/10H adds walkers busy with nested translation walks.
// - 51H/01H counts lines filled into the first-level data cache.
// - 5EH/01H counts cycles the reservation station is empty for the thread.
// - Threshold one, invert and edge on 5EH/01H count each empty period end.
// - 60H/01H adds outstanding demand data reads; threshold one or six gives cycles.
// - 60H/02H adds outstanding demand code reads; threshold one counts cycles.
// - 60H/04H adds outstanding read-for-ownership store transactions.
// - 60H/08H adds outstanding cacheable data read transactions.
// - Threshold one on an occupancy gives one per cycle of non-zero occupancy.
`timescale 1ns/1ps
module pes_decoder (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire pes_pkg::pes_cond_s cond_in,
    input  wire logic              ref_clock_pulse_in,
    input  wire logic [7:0]        s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [7:0]        s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic [7:0]             increment_out
);

    function automatic logic [7:0] bit_w(input logic b);
        bit_w = {7'h00, b};
    endfunction : bit_w

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        strb_merge = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction : strb_merge

    // Raw per-cycle increment of the selected event, zero if undefined
    function automatic logic [7:0] decode(input pes_pkg::pes_select_s s,
                                          input pes_pkg::pes_cond_s  c,
                                          input logic                ref_tick);
        logic run;
        run = !c.thread_halted || (s.any_thread_qualifier && !c.sibling_halted);
        decode = 8'h00;
        case (s.event_num)
            pes_pkg::EV_L2_REQ: begin
                case (s.umask)
                    pes_pkg::UM_E4: decode = bit_w(c.l2_code_req);
                    pes_pkg::UM_E7: decode = bit_w(c.l2_demand_req);
                    pes_pkg::UM_F8: decode = bit_w(c.l2_prefetch_req);
                    pes_pkg::UM_EF: decode = bit_w(c.l2_any_req);
                    default: decode = 8'h00;
                endcase
            end
            pes_pkg::EV_L3_CACHE: begin
                case (s.umask)
                    pes_pkg::UM_4F: decode = bit_w(c.l3_reference);
                    pes_pkg::UM_41: decode = bit_w(c.l3_miss);
                    default: decode = 8'h00;
                endcase
            end
            pes_pkg::EV_UNHALTED: begin
                case (s.umask)
                    pes_pkg::UM_00: decode = bit_w(run);
                    pes_pkg::UM_01: decode = bit_w(run && ref_tick);
                    pes_pkg::UM_02: begin
                        decode = bit_w(!c.thread_halted && c.sibling_halted && ref_tick);
                    end
                    default: decode = 8'h00;
                endcase
            end
            pes_pkg::EV_L1D_PEND: begin
                case (s.umask)
                    pes_pkg::UM_01: decode = c.l1d_miss_pending;
                    pes_pkg::UM_02: decode = bit_w(c.fill_buffer_entry_full_demand);
                    default: decode = 8'h00;
                endcase
            end
            pes_pkg::EV_STORE_TLB: begin
                case (s.umask)
                    pes_pkg::UM_01: decode = bit_w(c.store_walk_start);
                    pes_pkg::UM_0E: decode = bit_w(c.store_walk_done);
                    pes_pkg::UM_10: decode = c.page_walk_handler_store_busy;
                    pes_pkg::UM_20: decode = bit_w(c.store_second_level_tlb_hit);
                    default: decode = 8'h00;
                endcase
            end
            pes_pkg::EV_LOAD_HIT_PF: begin
                if (s.umask == pes_pkg::UM_01) begin
                    decode = bit_w(c.load_hit_sw_prefetch);
                end
            end
            pes_pkg::EV_NESTED: begin
                if (s.umask == pes_pkg::UM_10) begin
                    decode = c.page_walk_handler_nested_busy;
                end
            end
            pes_pkg::EV_L1D_FILL: begin
                if (s.umask == pes_pkg::UM_01) begin
                    decode = bit_w(c.l1d_line_fill);
                end
            end
            pes_pkg::EV_STN_EMPTY: begin
                if (s.umask == pes_pkg::UM_01) begin
                    decode = bit_w(c.reservation_station_empty);
                end
            end
            pes_pkg::EV_QUEUE_OCC: begin
                case (s.umask)
                    pes_pkg::UM_01: decode = c.super_queue_demand_data;
                    pes_pkg::UM_02: decode = c.super_queue_code;
                    pes_pkg::UM_04: decode = c.super_queue_read_for_ownership_request;
                    pes_pkg::UM_08: decode = c.super_queue_data;
                    default: decode = 8'h00;
                endcase
            end
            default: decode = 8'h00;
        endcase
    endfunction : decode

    // Reference pulse synchroniser and edge detect
    logic ref_sync1;
    logic ref_sync2;
    logic ref_prev;
    logic ref_tick;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_sync1 <= 1'b0;
            ref_sync2 <= 1'b0;
            ref_prev  <= 1'b0;
        end else begin
            ref_sync1 <= ref_clock_pulse_in;
            ref_sync2 <= ref_sync1;
            ref_prev  <= ref_sync2;
        end
    end
    assign ref_tick = ref_sync2 && !ref_prev;
    // Register bus and counting state
    pes_pkg::pes_select_s sel;
    pes_pkg::pes_select_s next_sel;
    logic [31:0]          count;
    logic [31:0]          next_count;
    logic [7:0]           next_increment;
    logic                 qual_prev;
    logic                 next_qual_prev;
    logic                 aw_held;
    logic                 next_aw_held;
    logic [7:0]           aw_addr;
    logic [7:0]           next_aw_addr;
    logic                 w_held;
    logic                 next_w_held;
    logic [31:0]          w_data;
    logic [31:0]          next_w_data;
    logic [3:0]           w_strb;
    logic [3:0]           next_w_strb;
    logic                 next_bvalid;
    logic [1:0]           next_bresp;
    logic                 next_rvalid;
    logic [31:0]          next_rdata;
    logic [1:0]           next_rresp;
    logic                 next_awready;
    logic                 next_wready;
    logic                 next_arready;
    logic [7:0]           raw;
    logic                 qual;
    always_comb begin
        raw = decode(sel, cond_in, ref_tick);
        // Threshold turns an occupancy into a per-cycle condition
        qual = (raw >= sel.threshold) ^ sel.invert_qualifier;
        next_qual_prev = qual;
        if (sel.threshold == 8'h00) begin
            next_increment = raw;
        end else if (sel.edge_detect) begin
            next_increment = bit_w(qual && !qual_prev);
        end else begin
            next_increment = bit_w(qual);
        end
        next_sel     = sel;
        next_count   = sel.enable ? count + {24'h000000, next_increment} : count;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid_out;
        next_bresp   = s_axi_bresp_out;
        next_rvalid  = s_axi_rvalid_out;
        next_rdata   = s_axi_rdata_out;
        next_rresp   = s_axi_rresp_out;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid_out) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = pes_pkg::RESP_OKAY;
            case (aw_addr)
                pes_pkg::REG_SELECT: begin
                    next_sel = strb_merge(sel, w_data, w_strb) & pes_pkg::SELECT_WMASK;
                end
                pes_pkg::REG_COUNT: next_count = strb_merge(count, w_data, w_strb);
                default: next_bresp = pes_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            next_rvalid = 1'b1;
            next_rresp  = pes_pkg::RESP_OKAY;
            case (s_axi_araddr_in)
                pes_pkg::REG_SELECT: next_rdata = sel;
                pes_pkg::REG_COUNT:  next_rdata = count;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = pes_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel               <= pes_pkg::SELECT_RESET;
            count             <= pes_pkg::COUNT_RESET;
            increment_out     <= 8'h00;
            qual_prev         <= 1'b0;
            aw_held           <= 1'b0;
            aw_addr           <= 8'h00;
            w_held            <= 1'b0;
            w_data            <= 32'h0000_0000;
            w_strb            <= 4'h0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= pes_pkg::RESP_OKAY;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= pes_pkg::RESP_OKAY;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_arready_out <= 1'b0;
        end else begin
            sel               <= next_sel;
            count             <= next_count;
            increment_out     <= next_increment;
            qual_prev         <= next_qual_prev;
            aw_held           <= next_aw_held;
            aw_addr           <= next_aw_addr;
            w_held            <= next_w_held;
            w_data            <= next_w_data;
            w_strb            <= next_w_strb;
            s_axi_bvalid_out  <= next_bvalid;
            s_axi_bresp_out   <= next_bresp;
            s_axi_rvalid_out  <= next_rvalid;
            s_axi_rdata_out   <= next_rdata;
            s_axi_rresp_out   <= next_rresp;
            s_axi_awready_out <= next_awready;
            s_axi_wready_out  <= next_wready;
            s_axi_arready_out <= next_arready;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic next_sel_change;
    assign next_sel_change = (next_sel != sel);
    logic plain;
    assign plain = (sel.threshold == 8'h00) && !next_sel_change;
    l2_code_count_a: assert property (
        (sel.event_num == pes_pkg::EV_L2_REQ && sel.umask == pes_pkg::UM_E4 && plain)
        |=> increment_out == bit_w($past(cond_in.l2_code_req)))
        else $error("code request increment wrong");
    l3_miss_count_a: assert property (
        (sel.event_num == pes_pkg::EV_L3_CACHE && sel.umask == pes_pkg::UM_41 && plain)
        |=> increment_out == bit_w($past(cond_in.l3_miss)))
        else $error("third level miss increment wrong");
    unhalted_cycle_a: assert property (
        (sel.event_num == pes_pkg::EV_UNHALTED && sel.umask == pes_pkg::UM_00 && plain
         && !sel.any_thread_qualifier && cond_in.thread_halted)
        |=> increment_out == 8'h00)
        else $error("halted thread counted");
    any_thread_a: assert property (
        (sel.event_num == pes_pkg::EV_UNHALTED && sel.umask == pes_pkg::UM_00 && plain
         && sel.any_thread_qualifier && !cond_in.sibling_halted)
        |=> increment_out == 8'h01)
        else $error("any thread cycle missed");
    one_thread_a: assert property (
        (sel.event_num == pes_pkg::EV_UNHALTED && sel.umask == pes_pkg::UM_02 && plain
         && !cond_in.sibling_halted)
        |=> increment_out == 8'h00)
        else $error("pulse counted with sibling running");
    fill_full_hw_a: assert property (
        (sel.event_num == pes_pkg::EV_L1D_PEND && sel.umask == pes_pkg::UM_02 && plain
         && !cond_in.fill_buffer_entry_full_demand)
        |=> increment_out == 8'h00)
        else $error("hardware prefetch counted as fill buffer full");
    station_empty_end_a: assert property (
        (sel.event_num == pes_pkg::EV_STN_EMPTY && sel.umask == pes_pkg::UM_01
         && sel.threshold == pes_pkg::THRESHOLD_ONE && sel.invert_qualifier
         && sel.edge_detect && !next_sel_change && $stable(sel)
         && $past(cond_in.reservation_station_empty) && !cond_in.reservation_station_empty)
        |=> increment_out == 8'h01)
        else $error("end of empty period missed");
    queue_six_a: assert property (
        (sel.event_num == pes_pkg::EV_QUEUE_OCC && sel.umask == pes_pkg::UM_01
         && sel.threshold == pes_pkg::THRESHOLD_SIX && !sel.invert_qualifier
         && !sel.edge_detect && !next_sel_change)
        |=> increment_out == bit_w($past(cond_in.super_queue_demand_data) >= 8'h06))
        else $error("threshold six cycle count wrong");
    occupancy_cycle_a: assert property (
        (sel.event_num == pes_pkg::EV_QUEUE_OCC && sel.umask == pes_pkg::UM_04
         && sel.threshold == pes_pkg::THRESHOLD_ONE && !sel.invert_qualifier
         && !sel.edge_detect && !next_sel_change)
        |=> increment_out == bit_w($past(cond_in.super_queue_read_for_ownership_request) != 8'h00))
        else $error("threshold one cycle count wrong");
    undefined_pair_a: assert property (
        (sel.event_num == pes_pkg::EV_L2_REQ && sel.umask == pes_pkg::UM_00 && plain)
        |=> increment_out == 8'h00)
        else $error("undefined selection incremented");
    write_resp_a: assert property (
        (aw_held && w_held && !s_axi_bvalid_out) |=> s_axi_bvalid_out)
        else $error("write response not raised");
    occupancy_cov: cover property (
        sel.event_num == pes_pkg::EV_L1D_PEND && increment_out > 8'h01);
    edge_cov: cover property (sel.edge_detect && increment_out == 8'h01);
    write_cov: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule : pes_decoder

// *** verilog/pes_pkg.sv ***
// Shared constants and types for the performance event select decoder
package pes_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_SELECT = 8'h00;
    localparam logic [7:0] REG_COUNT  = 8'h04;

    // Event numbers
    localparam logic [7:0] EV_L2_REQ      = 8'h24;
    localparam logic [7:0] EV_L3_CACHE    = 8'h2e;
    localparam logic [7:0] EV_UNHALTED    = 8'h3c;
    localparam logic [7:0] EV_L1D_PEND    = 8'h48;
    localparam logic [7:0] EV_STORE_TLB   = 8'h49;
    localparam logic [7:0] EV_LOAD_HIT_PF = 8'h4c;
    localparam logic [7:0] EV_NESTED      = 8'h4f;
    localparam logic [7:0] EV_L1D_FILL    = 8'h51;
    localparam logic [7:0] EV_STN_EMPTY   = 8'h5e;
    localparam logic [7:0] EV_QUEUE_OCC   = 8'h60;

    // Unit masks
    localparam logic [7:0] UM_00 = 8'h00;
    localparam logic [7:0] UM_01 = 8'h01;
    localparam logic [7:0] UM_02 = 8'h02;
    localparam logic [7:0] UM_04 = 8'h04;
    localparam logic [7:0] UM_08 = 8'h08;
    localparam logic [7:0] UM_0E = 8'h0e;
    localparam logic [7:0] UM_10 = 8'h10;
    localparam logic [7:0] UM_20 = 8'h20;
    localparam logic [7:0] UM_41 = 8'h41;
    localparam logic [7:0] UM_4F = 8'h4f;
    localparam logic [7:0] UM_E4 = 8'he4;
    localparam logic [7:0] UM_E7 = 8'he7;
    localparam logic [7:0] UM_EF = 8'hef;
    localparam logic [7:0] UM_F8 = 8'hf8;

    // Threshold values with a documented meaning
    localparam logic [7:0] THRESHOLD_ONE = 8'h01;
    localparam logic [7:0] THRESHOLD_SIX = 8'h06;

    // Reference clock rate in MHz
    localparam int REF_CLOCK_MHZ = 100;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] threshold;
        logic [3:0] reserved;
        logic       enable;
        logic       invert_qualifier;
        logic       any_thread_qualifier;
        logic       edge_detect;
        logic [7:0] umask;
        logic [7:0] event_num;
    } pes_select_s;

    localparam pes_select_s SELECT_RESET = '0;
    localparam pes_select_s SELECT_WMASK = 32'hff0f_ffff;

    // Per-cycle conditions and occupancy counts from the core
    typedef struct packed {
        logic       thread_halted;
        logic       sibling_halted;
        logic       l2_code_req;
        logic       l2_demand_req;
        logic       l2_prefetch_req;
        logic       l2_any_req;
        logic       l3_reference;
        logic       l3_miss;
        logic [7:0] l1d_miss_pending;
        logic       fill_buffer_entry_full_demand;
        logic       fill_buffer_entry_full_hw_prefetch;
        logic       store_walk_start;
        logic       store_walk_done;
        logic [7:0] page_walk_handler_store_busy;
        logic       store_second_level_tlb_hit;
        logic       load_hit_sw_prefetch;
        logic [7:0] page_walk_handler_nested_busy;
        logic       l1d_line_fill;
        logic       reservation_station_empty;
        logic [7:0] super_queue_demand_data;
        logic [7:0] super_queue_code;
        logic [7:0] super_queue_read_for_ownership_request;
        logic [7:0] super_queue_data;
    } pes_cond_s;
endpackage : pes_pkg
